// *** core/ext_bus_port.sv ***
/*
 * External parallel bus port: master access engine toward memories and
 * peers, slave capture of accesses into internal memory, lane mapping.
 * Assumes a core-side request pulse held stable until done, pin inputs
 * asynchronous to clk_sys, and an external resolver of pin enables.
 */
// Notes on behaviour
// - Master drives target address on address bus
// - As slave, take address bus as input
// - 32-bit words ride bits 47 to 16
// - 40-bit words ride bits 47 to 8
// - 16-bit words ride bits 31 to 16
// - Boot bytes ride bits 23 to 16
// - One active-low bank select per target bank
// - Selects follow address; inactive when idle
// - Select asserted even for false conditional
// - Bank span set by system control size
// - Read strobe low on master reads
// - Write strobe low on master writes
// - Only bus master drives strobes, selects, page
// - Page output on DRAM page crossing
// - Page output only for bank 0
// - Clock reference driven by master only
// - Early write hint; abandoned without strobe
// - Write hint with the address, same cycle
// - Slave uses write hint to pick direction
// - Float outputs when slave or float requested; clock reference floats only when slave
// - Low acknowledge stretches the access
`timescale 1ns/100ps
`include "ext_port_defs.svh"
module ext_bus_port
    import ext_port_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 48,
    parameter int BANKS = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    // Core request side
    input wire logic req,
    input wire logic req_write,
    input wire logic req_cond_true,
    input wire data_fmt_t req_fmt,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [39:0] req_wdata,
    output logic req_done,
    output logic [39:0] req_rdata,
    // Configuration from the system and memory control registers
    input wire logic [4:0] bank_size_log2,
    input wire logic [3:0] page_size_log2,
    input wire logic is_bus_master,
    // Address bus
    input wire logic [ADDR_W-1:0] ext_address_bus_i,
    output logic [ADDR_W-1:0] ext_address_bus_o,
    output logic ext_address_bus_oe,
    // Data bus
    input wire logic [DATA_W-1:0] ext_data_bus_i,
    output logic [DATA_W-1:0] ext_data_bus_o,
    output logic ext_data_bus_oe,
    // Bank selects
    output logic [BANKS-1:0] bank_selects_n,
    output logic bank_selects_oe,
    // Strobes, two-way
    input wire logic rd_strobe_n_i,
    output logic rd_strobe_n_o,
    input wire logic wr_strobe_n_i,
    output logic wr_strobe_n_o,
    output logic strobes_oe,
    input wire logic sync_store_hint_n_i,
    output logic sync_store_hint_n_o,
    output logic sync_store_hint_oe,
    // Page crossing and clock reference
    output logic page_cross,
    output logic page_oe,
    output logic bus_clock_ref,
    output logic bus_clock_ref_oe,
    // Wait and float controls
    input wire logic ack_i,
    input wire logic bus_float_request_n,
    // Slave side toward internal memory
    output logic slv_valid,
    output logic slv_write,
    output logic [ADDR_W-1:0] slv_addr,
    output logic [DATA_W-1:0] slv_wdata
);
    // Two-stage synchronisers for all pin inputs
    logic [3:0] ctl_s1_r, ctl_s2_r; // ack, float, rd, wr
    logic sw_s1_r, sw_s2_r; // write hint
    logic [ADDR_W-1:0] adr_s1_r, adr_s2_r; // slave address
    logic [DATA_W-1:0] dat_s1_r, dat_s2_r; // data bus
    mst_state_t state_r; // master state
    logic [ADDR_W-1:0] last_addr_r; // last bank 0 address
    logic last_valid_r; // last_addr_r holds a real access
    logic rd_n_d_r, wr_n_d_r; // previous synced strobes
    logic [47:0] lane_w;
    logic [39:0] lane_r;
    logic float_now; // outputs must release
    logic ack_s, float_n_s, rd_n_s, wr_n_s;
    logic [1:0] bank_idx;
    logic [ADDR_W-1:0] page_mask;
    logic [1:0] strb_age_r; // edges spent in the strobe phase
    logic ack_ok; // synced ack that truly answers this strobe

    // Synchronise asynchronous pins before use
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctl_s1_r <= 4'hf;
            ctl_s2_r <= 4'hf;
            sw_s1_r <= 1'b1;
            sw_s2_r <= 1'b1;
            adr_s1_r <= '0;
            adr_s2_r <= '0;
            dat_s1_r <= '0;
            dat_s2_r <= '0;
        end else begin
            ctl_s1_r <= {ack_i, bus_float_request_n, rd_strobe_n_i, wr_strobe_n_i};
            ctl_s2_r <= ctl_s1_r;
            sw_s1_r <= sync_store_hint_n_i;
            sw_s2_r <= sw_s1_r;
            adr_s1_r <= ext_address_bus_i;
            adr_s2_r <= adr_s1_r;
            dat_s1_r <= ext_data_bus_i;
            dat_s2_r <= dat_s1_r;
        end
    end

    assign ack_s = ctl_s2_r[3];
    assign float_n_s = ctl_s2_r[2];
    assign rd_n_s = ctl_s2_r[1];
    assign wr_n_s = ctl_s2_r[0];
    // Slave or float request releases every driven pin except the clock reference, whose enable follows mastership only
    assign float_now = !is_bus_master || !float_n_s;
    // Bank index sits just above the bank-size field
    assign bank_idx = 2'(req_addr >> bank_size_log2);
    assign page_mask = {ADDR_W{1'b1}} << page_size_log2;
    // Ack and read data lag two flops behind the pins; until the strobe has stood
    // that long the synced copies still show the idle bus and must be ignored
    assign ack_ok = (state_r == ST_STRB) && (strb_age_r == `SYNC_LAT_CYC) && ack_s;

    // Strobe-phase age, saturating at the synchroniser latency
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strb_age_r <= 2'h0;
        end else if (state_r != ST_STRB) begin
            strb_age_r <= 2'h0;
        end else if (strb_age_r != `SYNC_LAT_CYC) begin
            strb_age_r <= strb_age_r + 2'h1;
        end
    end

    lane_mux u_lane (
        .fmt(req_fmt),
        .core_wdata(req_wdata),
        .bus_rdata(dat_s2_r),
        .bus_wdata(lane_w),
        .core_rdata(lane_r)
    );

    // Master access sequencer; a float request halts it until released
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (req && !float_now) state_r <= ST_ADDR;
                ST_ADDR: if (!float_now) state_r <= ST_STRB;
                // Access holds while acknowledge is low
                ST_STRB: if (ack_ok && !float_now) state_r <= ST_DONE;
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Address, selects and write hint launch together
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_address_bus_o <= '0;
            bank_selects_n <= '1;
            sync_store_hint_n_o <= 1'b1;
        end else if (state_r == ST_IDLE && req && !float_now) begin
            ext_address_bus_o <= req_addr;
            // Select drives even when the condition is false
            bank_selects_n <= ~(BANKS'(1) << bank_idx);
            sync_store_hint_n_o <= !req_write;
        end else if (state_r == ST_DONE || state_r == ST_IDLE) begin
            bank_selects_n <= '1;
            sync_store_hint_n_o <= 1'b1;
        end
    end

    // Strobes: only for a true condition, so a false write is abandoned
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_strobe_n_o <= 1'b1;
            wr_strobe_n_o <= 1'b1;
            ext_data_bus_o <= '0;
        end else if (state_r == ST_ADDR && !float_now && req_cond_true) begin
            rd_strobe_n_o <= req_write;
            wr_strobe_n_o <= !req_write;
            ext_data_bus_o <= lane_w;
        end else if (ack_ok) begin
            rd_strobe_n_o <= 1'b1;
            wr_strobe_n_o <= 1'b1;
        end
    end

    // Page crossing flag, bank 0 only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            page_cross <= 1'b0;
            last_addr_r <= '0;
            last_valid_r <= 1'b0;
        end else if (state_r == ST_IDLE && req && !float_now) begin
            if (bank_idx == `DRAM_BANK) begin
                page_cross <= last_valid_r &&
                    ((req_addr & page_mask) != (last_addr_r & page_mask));
                last_addr_r <= req_addr;
                last_valid_r <= 1'b1;
            end else begin
                page_cross <= 1'b0;
            end
        end else if (state_r == ST_DONE) begin
            page_cross <= 1'b0;
        end
    end

    // Pin enables follow mastership and the float request; the clock reference enable follows mastership only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_address_bus_oe <= 1'b0;
            ext_data_bus_oe <= 1'b0;
            bank_selects_oe <= 1'b0;
            strobes_oe <= 1'b0;
            sync_store_hint_oe <= 1'b0;
            page_oe <= 1'b0;
            bus_clock_ref_oe <= 1'b0;
        end else begin
            ext_address_bus_oe <= !float_now;
            ext_data_bus_oe <= !float_now && req_write && state_r != ST_IDLE;
            bank_selects_oe <= !float_now;
            strobes_oe <= !float_now;
            sync_store_hint_oe <= !float_now;
            page_oe <= !float_now;
            bus_clock_ref_oe <= is_bus_master;
        end
    end

    // Clock reference: half-rate toggle so it can come from a flop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus_clock_ref <= 1'b0;
        end else begin
            bus_clock_ref <= !bus_clock_ref;
        end
    end

    // Core completion and read data
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_done <= 1'b0;
            req_rdata <= '0;
        end else begin
            req_done <= ack_ok && !float_now;
            if (ack_ok && !req_write) begin
                req_rdata <= lane_r;
            end
        end
    end

    // Slave capture on the falling edge of an outside strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_n_d_r <= 1'b1;
            wr_n_d_r <= 1'b1;
            slv_valid <= 1'b0;
            slv_write <= 1'b0;
            slv_addr <= '0;
            slv_wdata <= '0;
        end else begin
            rd_n_d_r <= rd_n_s;
            wr_n_d_r <= wr_n_s;
            slv_valid <= 1'b0;
            if (!is_bus_master && ((rd_n_d_r && !rd_n_s) || (wr_n_d_r && !wr_n_s))) begin
                slv_valid <= 1'b1;
                // Write hint low marks a write; strobe covers async hosts
                slv_write <= !sw_s2_r || !wr_n_s;
                slv_addr <= adr_s2_r;
                slv_wdata <= dat_s2_r;
            end
        end
    end

    // Write hint and select launch in the same cycle as the address
    sequence s_launch;
        state_r == ST_IDLE && req && !float_now;
    endsequence
    property p_hint_with_addr;
        @(posedge clk_sys) disable iff (!arst_n)
        s_launch ##1 1'b1 |-> (sync_store_hint_n_o == !$past(req_write))
            && ext_address_bus_o == $past(req_addr);
    endproperty
    a_hint_with_addr: assert property (p_hint_with_addr) else $error("hint not with addr");
    property p_sel_on_launch;
        @(posedge clk_sys) disable iff (!arst_n)
        s_launch |=> $countones(~bank_selects_n) == 1;
    endproperty
    a_sel_on_launch: assert property (p_sel_on_launch) else $error("no select");
    property p_idle_no_sel;
        @(posedge clk_sys) disable iff (!arst_n)
        state_r == ST_IDLE && !req |=> bank_selects_n == '1;
    endproperty
    a_idle_no_sel: assert property (p_idle_no_sel) else $error("select while idle");
    property p_false_cond;
        @(posedge clk_sys) disable iff (!arst_n)
        state_r == ST_ADDR && !req_cond_true && !float_now |=> wr_strobe_n_o && rd_strobe_n_o;
    endproperty
    a_false_cond: assert property (p_false_cond) else $error("strobe on false");
    property p_page_bank0;
        @(posedge clk_sys) disable iff (!arst_n)
        s_launch and (bank_idx != `DRAM_BANK) |=> !page_cross;
    endproperty
    a_page_bank0: assert property (p_page_bank0) else $error("page off bank 0");
    property p_wait_ack;
        @(posedge clk_sys) disable iff (!arst_n)
        state_r == ST_STRB && !ack_s |=> !req_done;
    endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("done during wait");
    property p_float;
        @(posedge clk_sys) disable iff (!arst_n)
        float_now |=> !ext_address_bus_oe && !strobes_oe && !bank_selects_oe;
    endproperty
    a_float: assert property (p_float) else $error("drives while floating");
    property p_rd_strobe;
        @(posedge clk_sys) disable iff (!arst_n)
        state_r == ST_ADDR && req_cond_true && !req_write && !float_now |=> !rd_strobe_n_o;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("no read strobe");
    property p_clkref;
        @(posedge clk_sys) disable iff (!arst_n)
        !is_bus_master |=> !bus_clock_ref_oe;
    endproperty
    a_clkref: assert property (p_clkref) else $error("clock ref as slave");
    // No completion before the synced ack can reflect the strobe
    property p_sync_wait;
        @(posedge clk_sys) disable iff (!arst_n)
        state_r == ST_STRB && strb_age_r != `SYNC_LAT_CYC |=> !req_done;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("done before ack settled");
endmodule

// *** core/ext_port_defs.svh ***
/*
 * Constants of the external bus port: lane positions, bank decode, timing.
 * Assumes inclusion by bare name from the port modules.
 */
`ifndef EXT_PORT_DEFS_SVH
`define EXT_PORT_DEFS_SVH

// Lane low bits per data format (upper bit always 47 except short word and byte)
`define LANE_W32_LSB 16
`define LANE_W40_LSB 8
`define LANE_W16_LSB 16
`define LANE_W16_MSB 31
`define LANE_B8_LSB 16
`define LANE_B8_MSB 23
// Bank-size field: bank n spans addresses with bits above the size field
`define BANK_SIZE_RST 5'h0e
`define PAGE_SIZE_RST 4'h8
// Bank 0 is the only bank allowed to hold DRAM
`define DRAM_BANK 2'h0
// Cycles spent in the address phase before strobes
`define ADDR_SETUP_CYC 1
// Edges a pin change needs to reach the second synchroniser flop
`define SYNC_LAT_CYC 2'h2
`endif

// *** core/ext_port_pkg.sv ***
/*
 * Types of the external bus port.
 * Assumes the defs header is on the include path.
 */
package ext_port_pkg;
    // Data formats carried on the data bus
    typedef enum logic [2:0] {
        FMT_W32 = 3'h0,
        FMT_W40 = 3'h1,
        FMT_W16 = 3'h2,
        FMT_B8 = 3'h3
    } data_fmt_t;
    // Master-side access states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_STRB = 4'b0100,
        ST_DONE = 4'b1000
    } mst_state_t;
endpackage

// *** core/lane_mux.sv ***
/*
 * Lane mapper: places a core word on the data-bus lanes of its format and
 * extracts a core word from the bus. Purely combinational.
 * Assumes the caller registers results before they reach any pin.
 */
`timescale 1ns/100ps
`include "ext_port_defs.svh"
module lane_mux
    import ext_port_pkg::*;
(
    input wire data_fmt_t fmt,
    input wire logic [39:0] core_wdata,
    input wire logic [47:0] bus_rdata,
    output logic [47:0] bus_wdata,
    output logic [39:0] core_rdata
);
    // Unused lanes are driven zero on writes and dropped on reads
    always_comb begin
        bus_wdata = 48'h0;
        core_rdata = 40'h0;
        case (fmt)
            FMT_W32: begin
                bus_wdata[47:`LANE_W32_LSB] = core_wdata[31:0];
                core_rdata[31:0] = bus_rdata[47:`LANE_W32_LSB];
            end
            FMT_W40: begin
                bus_wdata[47:`LANE_W40_LSB] = core_wdata;
                core_rdata = bus_rdata[47:`LANE_W40_LSB];
            end
            FMT_W16: begin
                bus_wdata[`LANE_W16_MSB:`LANE_W16_LSB] = core_wdata[15:0];
                core_rdata[15:0] = bus_rdata[`LANE_W16_MSB:`LANE_W16_LSB];
            end
            FMT_B8: begin
                bus_wdata[`LANE_B8_MSB:`LANE_B8_LSB] = core_wdata[7:0];
                core_rdata[7:0] = bus_rdata[`LANE_B8_MSB:`LANE_B8_LSB];
            end
            default: begin
                bus_wdata = 48'h0;
                core_rdata = 40'h0;
            end
        endcase
    end
endmodule

// *** tb/ext_mem_model.sv ***
/*
 * Behavioural external memory on the far side of the bus port.
 * Assumes resolved strobe levels and the port's data-bus outputs.
 */
`timescale 1ns/100ps
module ext_mem_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [47:0] bus_wdata,
    input wire logic bus_oe,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [47:0] rd_word,
    input wire logic [3:0] wait_cyc,
    output logic ack,
    output logic [47:0] bus_rdata,
    output logic [47:0] wr_word
);
    logic [3:0] wait_cnt_r; // Wait states still owed
    logic strb_d_r; // Strobe level one cycle ago
    logic [47:0] last_r; // Last value put on the data bus
    logic strb;
    logic strb_fell;
    assign strb = !rd_n || !wr_n;
    assign strb_fell = strb && !strb_d_r;
    // Ack held low from the strobe's fall for the set wait count
    assign ack = !((wait_cnt_r != 4'h0) || (strb_fell && wait_cyc != 4'h0));
    // Full word on reads, junk in lanes the format leaves unused
    assign bus_rdata = !rd_n ? rd_word : ~last_r;
    // Wait counter and strobe edge history
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt_r <= 4'h0;
            strb_d_r <= 1'b0;
        end else begin
            strb_d_r <= strb;
            if (strb_fell && wait_cyc != 4'h0) begin
                wait_cnt_r <= wait_cyc - 4'h1;
            end else if (wait_cnt_r != 4'h0) begin
                wait_cnt_r <= wait_cnt_r - 4'h1;
            end
        end
    end
    // Capture writes; remember driven value so a released bus flips
    always_ff @(posedge clk_sys) begin
        if (!wr_n && bus_oe) begin
            wr_word <= bus_wdata;
        end
        if (!rd_n) begin
            last_r <= rd_word;
        end
    end
endmodule

// *** tb/tb_external_port_bus_interface.sv ***
/*
 * Self-checking bench of the bus port: master formats, selects, hints,
 * pages, waits, float and slave capture.
 * Assumes the port package and an external memory model.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_external_port_bus_interface;
    import ext_port_pkg::*;
    localparam logic [47:0] RDW = 48'ha5c3_1e96_7b2d; // Read word with junk lanes
    localparam logic [39:0] WD = 40'h9c_4b2e_7d13; // Write word
    localparam logic [31:0] A1 = 32'h0100_0040; // Bank 1 address
    logic clk_sys, arst_n, req, req_write, req_cond_true, req_done, is_bus_master;
    data_fmt_t req_fmt;
    logic [31:0] req_addr, ea_o, addr_i, tb_addr, slv_addr, addr_seen;
    logic [39:0] req_wdata, req_rdata, got;
    logic [47:0] ed_o, data_i, tb_data, slv_wdata, mdl_rd, mdl_wr;
    logic [3:0] bank_selects_n, sel_seen, wait_cyc;
    logic ea_oe, ed_oe, bank_selects_oe, rd_o, wr_o, strobes_oe, hint_o, hint_oe;
    logic page_cross, page_oe, bus_clock_ref, bus_clock_ref_oe, ack_i, bus_float_request_n;
    logic slv_valid, slv_write, tb_rd_n, tb_wr_n, tb_hint_n, tb_drv, rd_i, wr_i, hint_i;
    logic wr_seen, rd_seen, hint_seen, hint_first, page_seen;
    int error_cnt = 0, samples_checked = 0, cyc;
    // Resolve each shared line from all enables
    assign addr_i = ea_oe ? ea_o : tb_addr;
    assign data_i = ed_oe ? ed_o : (tb_drv ? tb_data : mdl_rd);
    assign rd_i = strobes_oe ? rd_o : tb_rd_n;
    assign wr_i = strobes_oe ? wr_o : tb_wr_n;
    assign hint_i = hint_oe ? hint_o : tb_hint_n;
    ext_bus_port ext_bus_port_i (.clk_sys(clk_sys), .arst_n(arst_n), .req(req),
        .req_write(req_write), .req_cond_true(req_cond_true), .req_fmt(req_fmt),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata),
        .bank_size_log2(5'h18), .page_size_log2(4'h8), .is_bus_master(is_bus_master),
        .ext_address_bus_i(addr_i), .ext_address_bus_o(ea_o), .ext_address_bus_oe(ea_oe),
        .ext_data_bus_i(data_i), .ext_data_bus_o(ed_o), .ext_data_bus_oe(ed_oe),
        .bank_selects_n(bank_selects_n), .bank_selects_oe(bank_selects_oe),
        .rd_strobe_n_i(rd_i), .rd_strobe_n_o(rd_o), .wr_strobe_n_i(wr_i),
        .wr_strobe_n_o(wr_o), .strobes_oe(strobes_oe), .sync_store_hint_n_i(hint_i),
        .sync_store_hint_n_o(hint_o), .sync_store_hint_oe(hint_oe), .page_cross(page_cross),
        .page_oe(page_oe), .bus_clock_ref(bus_clock_ref), .bus_clock_ref_oe(bus_clock_ref_oe),
        .ack_i(ack_i), .bus_float_request_n(bus_float_request_n), .slv_valid(slv_valid),
        .slv_write(slv_write), .slv_addr(slv_addr), .slv_wdata(slv_wdata));
    ext_mem_model ext_mem_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .bus_wdata(ed_o),
        .bus_oe(ed_oe), .rd_n(rd_i), .wr_n(wr_i), .rd_word(RDW), .wait_cyc(wait_cyc),
        .ack(ack_i), .bus_rdata(mdl_rd), .wr_word(mdl_wr));
    // Where a core word should sit on the bus
    function automatic logic [47:0] on_bus(data_fmt_t f, logic [39:0] w);
        case (f)
            FMT_W32: return {w[31:0], 16'h0};
            FMT_W40: return {w, 8'h0};
            FMT_W16: return {16'h0, w[15:0], 16'h0};
            default: return {24'h0, w[7:0], 16'h0};
        endcase
    endfunction
    // What a core read should extract from the bus
    function automatic logic [39:0] off_bus(data_fmt_t f, logic [47:0] b);
        case (f)
            FMT_W32: return {8'h0, b[47:16]};
            FMT_W40: return b[47:8];
            FMT_W16: return {24'h0, b[31:16]};
            default: return {32'h0, b[23:16]};
        endcase
    endfunction
    // One master access; watches the pins every cycle until done
    task automatic access(input logic w, input logic c, input data_fmt_t f,
        input logic [31:0] a, input logic [3:0] wt);
        req_write = w;
        req_cond_true = c;
        req_fmt = f;
        req_addr = a;
        req_wdata = WD;
        wait_cyc = wt;
        req = 1'b1;
        sel_seen = 4'hf;
        {wr_seen, rd_seen, hint_seen, hint_first, page_seen} = 5'h0;
        cyc = 0;
        @(negedge clk_sys);
        while (req_done !== 1'b1 && cyc < 40) begin
            // First cycle with a select low fixes address and hint
            if (bank_selects_oe === 1'b1 && sel_seen === 4'hf && bank_selects_n !== 4'hf) begin
                hint_first = (hint_oe === 1'b1 && hint_o === 1'b0);
                addr_seen = ea_o;
            end
            if (bank_selects_oe === 1'b1) sel_seen &= bank_selects_n;
            if (strobes_oe === 1'b1 && wr_o === 1'b0) wr_seen = 1'b1;
            if (strobes_oe === 1'b1 && rd_o === 1'b0) rd_seen = 1'b1;
            if (hint_oe === 1'b1 && hint_o === 1'b0) hint_seen = 1'b1;
            if (page_oe === 1'b1 && page_cross === 1'b1) page_seen = 1'b1;
            cyc++;
            @(negedge clk_sys);
        end
        got = req_rdata;
        req = 1'b0;
        @(negedge clk_sys);
    endtask
    // Every format written then read on bank 1
    task automatic t_formats();
        data_fmt_t f;
        for (int i = 0; i < 4; i++) begin
            f = data_fmt_t'(i);
            access(1'b1, 1'b1, f, A1, 4'h0);
            `CHK(mdl_wr & on_bus(f, 40'hff_ffff_ffff), on_bus(f, WD))
            `CHK(sel_seen, 4'hd)
            `CHK({wr_seen, rd_seen, hint_first}, 3'b101)
            `CHK(addr_seen, A1)
            `CHK(bus_clock_ref_oe, 1'b1)
            access(1'b0, 1'b1, f, A1, 4'h0);
            `CHK(got, off_bus(f, RDW))
            `CHK({wr_seen, rd_seen, hint_seen}, 3'b010)
            `CHK(bank_selects_n, 4'hf)
        end
        $display("test formats done");
    endtask
    // False conditional write: select and hint, never the strobe
    task automatic t_cond();
        access(1'b1, 1'b0, FMT_W32, 32'h0300_0008, 4'h0);
        `CHK(sel_seen, 4'h7)
        `CHK({wr_seen, hint_seen}, 2'b01)
        $display("test conditional done");
    endtask
    // Page output on a bank-0 page change only; ack stretches access
    task automatic t_page_wait();
        int base;
        access(1'b0, 1'b1, FMT_W32, 32'h0000_0010, 4'h0);
        base = cyc;
        `CHK(base >= 4, 1'b1)
        access(1'b0, 1'b1, FMT_W32, 32'h0000_0020, 4'h0);
        `CHK(page_seen, 1'b0)
        access(1'b0, 1'b1, FMT_W32, 32'h0000_0110, 4'h3);
        `CHK(page_seen, 1'b1)
        `CHK(cyc >= base + 3, 1'b1)
        access(1'b0, 1'b1, FMT_W32, 32'h0100_0300, 4'h0);
        `CHK(page_seen, 1'b0)
        $display("test page and wait done");
    endtask
    // Float request halts a pending access until released
    task automatic t_float();
        bus_float_request_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        {req_write, req_cond_true, req_fmt, req_addr, req} = {2'b01, FMT_W32, A1, 1'b1};
        hint_seen = 1'b0;
        repeat (8) begin
            @(negedge clk_sys);
            if (req_done === 1'b1) hint_seen = 1'b1;
        end
        `CHK(hint_seen, 1'b0)
        `CHK({ea_oe, ed_oe, bank_selects_oe, strobes_oe}, 4'h0)
        bus_float_request_n = 1'b1;
        cyc = 0;
        while (req_done !== 1'b1 && cyc < 40) begin
            @(negedge clk_sys);
            cyc++;
        end
        `CHK(req_done, 1'b1)
        req = 1'b0;
        @(negedge clk_sys);
        $display("test float done");
    endtask
    // Outside master writes then reads our internal memory
    task automatic slave_op(input logic w, input logic [31:0] a, input logic [47:0] d);
        {tb_addr, tb_data, tb_drv, tb_hint_n} = {a, d, 1'b1, !w};
        if (w) tb_wr_n = 1'b0;
        else tb_rd_n = 1'b0;
        cyc = 0;
        while (slv_valid !== 1'b1 && cyc < 10) begin
            @(negedge clk_sys);
            cyc++;
        end
        `CHK({slv_valid, slv_write, slv_addr}, {1'b1, w, a})
        if (w) `CHK(slv_wdata, d)
        {tb_rd_n, tb_wr_n, tb_hint_n, tb_drv, tb_addr} = {3'h7, 1'b0, ~a};
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic t_slave();
        got[0] = bus_clock_ref;
        @(negedge clk_sys);
        `CHK(bus_clock_ref, !got[0])
        is_bus_master = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK({ea_oe, ed_oe, bank_selects_oe, strobes_oe, page_oe, bus_clock_ref_oe}, 6'h0)
        slave_op(1'b1, 32'h0000_2468, 48'h3c5a_96f0_1e2d);
        slave_op(1'b0, 32'h0000_1357, 48'h0);
        is_bus_master = 1'b1;
        $display("test slave done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Free-running system clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog cuts a hang short far beyond the expected run
    initial begin
        #2000000;
        error_cnt++;
        end_of_test();
    end
    // Main sequence: reset, then each scenario in turn
    initial begin
        {arst_n, req, req_write, req_cond_true, req_addr, req_wdata} = '0;
        {is_bus_master, bus_float_request_n, tb_rd_n, tb_wr_n, tb_hint_n} = 5'h1f;
        {tb_drv, tb_addr, tb_data, wait_cyc, req_fmt} = '0;
        repeat (6) @(negedge clk_sys);
        `CHK({ea_oe, strobes_oe, bank_selects_n}, 6'h0f)
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_formats();
        t_cond();
        t_page_wait();
        t_float();
        t_slave();
        end_of_test();
    end
endmodule
